// *** hdl/arsiu_pkg.sv ***
// Constants for the audio receiver status and interrupt unit.
// Assumes one core clock domain and an asynchronous active-low reset.
// Functional notes
// - Unmask bits gate status and interrupt output
// - Two-bit trigger: onset, removal, level, reserved
// - Other interrupt sources have no trigger field; their event inputs set status on every cycle they are high
// - Output polarity set only by polarity field
// - Summary follows channel A or B by select
// - Ancillary width reported as four-bit code
// - Format flag 1 professional; pre-shaping 0 emphasised
// - Copy flag 0 asserted; General category forces asserted
// - First-issue flag from L bit alone
// - Professional or idle receiver forces both flags
// - Format flags set on detection, four stream types mutually exclusive
// - Silence after 2047 constant samples both channels
// - Fault bits sticky, read clears unless level persists
// - Fault sources updated at their own boundaries
// - Fault bits: subcode, channel status, unlock, validity, trust, line code, parity
// - Status sticky since read, masked bits read zero
// - Burst type change or burst flag rise fires
// - Slip fires per dropped or repeated sample, only on an asynchronous slave output port
// - Channel-status change over ten bytes fires
// - Format change fires only on rising flags
// - Buffer transfer completion raises interrupt
// - Masked fault leaves register, interrupt, sample alone
package arsiu_pkg;

  localparam logic [7:0] ADDR_RX_ERROR_UNMASK = 8'h0e;
  localparam logic [7:0] ADDR_IRQ_UNMASK = 8'h0f;
  localparam logic [7:0] ADDR_IRQ_TRIGGER_MODE = 8'h10;
  localparam logic [7:0] ADDR_RX_CS_SUMMARY = 8'h11;
  localparam logic [7:0] ADDR_STREAM_FORMAT_DETECT = 8'h12;
  localparam logic [7:0] ADDR_RX_FAULT_FLAGS = 8'h13;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;

  localparam logic [7:0] RST_IRQ_UNMASK = 8'h00;
  localparam logic [7:0] RST_IRQ_TRIGGER_MODE = 8'h00;
  localparam logic [7:0] RST_RX_ERROR_UNMASK = 8'h00;

  // Writable bits
  localparam logic [7:0] WMASK_TRIGGER_MODE = 8'h0f;
  localparam logic [7:0] WMASK_RX_ERROR_UNMASK = 8'h7f;

  // Interrupt status bit positions
  localparam int IRQ_BURST_TYPE_CHANGED = 7;
  localparam int IRQ_OUTPUT_SAMPLE_SKIP = 6;
  localparam int IRQ_CS_BUFFER_MOVED = 5;
  localparam int IRQ_CS_CONTENT_CHANGED = 4;
  localparam int IRQ_RX_FAULT_SUMMARY = 3;
  localparam int IRQ_SUBCODE_BLOCK_READY = 2;
  localparam int IRQ_STREAM_FORMAT_CHANGED = 1;
  localparam int IRQ_CONVERTER_LOCK_LOST = 0;

  // Receiver fault bit positions
  localparam int FLT_SUBCODE_CHECK = 6;
  localparam int FLT_CS_CHECK = 5;
  localparam int FLT_UNLOCK = 4;
  localparam int FLT_VALIDITY = 3;
  localparam int FLT_TRUST = 2;
  localparam int FLT_LINE_CODE = 1;
  localparam int FLT_FRAME_CHECK = 0;
  // Faults that may hold the current sample
  localparam logic [6:0] FLT_SAMPLE_GROUP = 7'h1f;

  // Trigger field positions in the mode register
  localparam int TRIG_RX_FAULT_LSB = 2;
  localparam int TRIG_CONVERTER_LSB = 0;

  typedef enum logic [1:0] {
    ARSIU_TRIG_ONSET = 2'b00,
    ARSIU_TRIG_REMOVAL = 2'b01,
    ARSIU_TRIG_LEVEL = 2'b10,
    ARSIU_TRIG_RSVD = 2'b11
  } arsiu_trig_t;

  // Output polarity codes
  localparam logic [1:0] POL_HIGH = 2'b00;
  localparam logic [1:0] POL_LOW = 2'b01;
  localparam logic [1:0] POL_LOW_OPEN_DRAIN = 2'b10;

  // Channel-status field positions within the five bytes
  localparam int CS_PRO_BIT = 0;
  localparam int CS_COPY_BIT = 2;
  localparam int CS_L_BIT = 15;
  localparam int CS_CAT_LSB = 8;
  localparam int CS_CON_PRE_SHAPING_FLAG_LSB = 3;
  localparam int CS_PRO_PRE_SHAPING_FLAG_LSB = 2;
  localparam logic [7:0] CS_CAT_GENERAL = 8'h00;
  localparam logic [2:0] CS_CON_PRE_SHAPING_FLAG_5015 = 3'b001;
  localparam logic [2:0] CS_PRO_PRE_SHAPING_FLAG_5015 = 3'b011;

  // Stream format detect bit positions
  localparam int FMT_PCM = 7;
  localparam int FMT_BURST = 6;
  localparam int FMT_COMP_A = 5;
  localparam int FMT_COMP_B = 4;
  localparam int FMT_EXT_DISC = 3;
  localparam int FMT_SILENCE = 2;

  // Silence detection
  localparam int SILENCE_SAMPLES = 2047;
  localparam int SILENCE_CNT_W = 11;
  localparam int SAMPLE_W = 24;

endpackage

// *** hdl/arsiu_trigger.sv ***
// Trigger-mode detector for one interrupt condition.
// Assumes the condition is a level synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module arsiu_trigger
  import arsiu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic cond,
  input wire arsiu_pkg::arsiu_trig_t mode,
  output logic fire,
  output logic level_hold
);

  logic cond_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_q <= 1'b0;
    end else begin
      cond_q <= cond;
    end
  end

  // Onset, removal or level event; reserved gives nothing
  always_comb begin
    case (mode)
      ARSIU_TRIG_ONSET: fire = cond & ~cond_q;
      ARSIU_TRIG_REMOVAL: fire = ~cond & cond_q;
      ARSIU_TRIG_LEVEL: fire = cond;
      default: fire = 1'b0;
    endcase
  end

  assign level_hold = (mode == ARSIU_TRIG_LEVEL) & cond;

endmodule
`default_nettype wire

// *** hdl/arsiu_silence.sv ***
// Digital silence detector over a stereo sample stream.
// Assumes sample_tick marks one new valid left/right pair.
`timescale 1ns/1ps
`default_nettype none
module arsiu_silence
  import arsiu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sample_tick,
  input wire logic [SAMPLE_W-1:0] sample_l,
  input wire logic [SAMPLE_W-1:0] sample_r,
  output logic silence
);

  localparam logic [SILENCE_CNT_W-1:0] CNT_FULL = SILENCE_CNT_W'(SILENCE_SAMPLES);

  logic [SAMPLE_W-1:0] last_value;
  logic [SILENCE_CNT_W-1:0] run_cnt;
  logic same;

  assign same = (sample_l == sample_r) && (sample_l == last_value);

  // Count of consecutive constant samples, saturating
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_cnt <= '0;
      last_value <= '0;
    end else if (sample_tick) begin
      last_value <= sample_l;
      if (sample_l != sample_r) begin
        run_cnt <= '0;
      end else if (!same || run_cnt == '0) begin
        run_cnt <= SILENCE_CNT_W'(1);
      end else if (run_cnt != CNT_FULL) begin
        run_cnt <= run_cnt + SILENCE_CNT_W'(1);
      end
    end
  end

  assign silence = (run_cnt == CNT_FULL);

endmodule
`default_nettype wire

// *** hdl/arsiu_top.sv ***
// Status and interrupt unit of an audio receiver with rate converter.
// Assumes a byte-wide register strobe port and receiver events on core_clk.
`timescale 1ns/1ps
`default_nettype none
module arsiu_top
  import arsiu_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic subframe_tick,
  input wire logic cs_block_tick,
  input wire logic subcode_block_tick,
  input wire logic err_validity,
  input wire logic err_trust,
  input wire logic err_line_code,
  input wire logic err_frame_check,
  input wire logic err_cs_check,
  input wire logic err_subcode_check,
  input wire logic rx_unlocked,
  input wire logic rx_in_use,
  input wire logic side_select,
  input wire logic [39:0] cs_a,
  input wire logic [39:0] cs_b,
  input wire logic [3:0] anc_width_a,
  input wire logic [3:0] anc_width_b,
  input wire logic pcm_found,
  input wire logic burst_found,
  input wire logic compressed_a_found,
  input wire logic compressed_b_found,
  input wire logic extended_disc_found,
  input wire logic sample_tick,
  input wire logic [SAMPLE_W-1:0] sample_l,
  input wire logic [SAMPLE_W-1:0] sample_r,
  input wire logic burst_type_tick,
  input wire logic [7:0] burst_type_byte,
  input wire logic out_port_slave,
  input wire logic out_frame_clock_async,
  input wire logic output_sample_skip,
  input wire logic cs_buffer_moved,
  input wire logic subcode_block_ready,
  input wire logic converter_lock_lost,
  input wire logic [1:0] int_polarity,
  output logic irq_active,
  output logic irq_pin,
  output logic irq_pin_oe_n,
  output logic fault_hold_sample
);

  function automatic logic [7:0] rise(input logic [7:0] now, input logic [7:0] was);
    rise = now & ~was;
  endfunction

  logic [7:0] irq_unmask, irq_trigger_mode, irq_status, irq_unmask_eff, status_keep;
  logic [7:0] fmt_q, fmt_rise, burst_type_prev, rx_cs_summary, stream_format_detect;
  logic [7:0] irq_events, next_rdata;
  logic [6:0] rx_error_unmask, rx_unmask_eff, fault_src, fault_new, rx_fault_flags;
  logic [2:0] tick_q;
  logic [79:0] cs_prev;
  logic burst_change_evt, cs_change_evt, rd_fault, rd_status, rx_fault_level;
  logic rx_fault_fire, rx_fault_hold, conv_fire, conv_hold, silence_found;

  //////////////////////////////////////////////////////////////////////////
  // Control registers
  assign rd_fault = reg_rd && (reg_addr == ADDR_RX_FAULT_FLAGS);
  assign rd_status = reg_rd && (reg_addr == ADDR_IRQ_STATUS);
  assign irq_unmask_eff = (reg_wr && reg_addr == ADDR_IRQ_UNMASK) ? reg_wdata : irq_unmask;
  assign rx_unmask_eff = (reg_wr && reg_addr == ADDR_RX_ERROR_UNMASK) ? reg_wdata[6:0]
                                                                     : rx_error_unmask;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_unmask <= RST_IRQ_UNMASK;
      irq_trigger_mode <= RST_IRQ_TRIGGER_MODE;
      rx_error_unmask <= RST_RX_ERROR_UNMASK[6:0];
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_IRQ_UNMASK: irq_unmask <= reg_wdata;
        ADDR_IRQ_TRIGGER_MODE: irq_trigger_mode <= reg_wdata & WMASK_TRIGGER_MODE;
        ADDR_RX_ERROR_UNMASK: rx_error_unmask <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Receiver fault sources and sticky flags
  // Each source sampled at its own boundary
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_src <= '0;
      tick_q <= '0;
    end else begin
      tick_q <= {subcode_block_tick, cs_block_tick, subframe_tick};
      if (subcode_block_tick) begin
        fault_src[FLT_SUBCODE_CHECK] <= err_subcode_check;
      end
      if (cs_block_tick) begin
        fault_src[FLT_CS_CHECK] <= err_cs_check & cs_a[CS_PRO_BIT];
        fault_src[FLT_UNLOCK] <= rx_unlocked;
      end
      if (subframe_tick) begin
        fault_src[FLT_VALIDITY] <= err_validity;
        fault_src[FLT_TRUST] <= err_trust;
        fault_src[FLT_LINE_CODE] <= err_line_code;
        fault_src[FLT_FRAME_CHECK] <= err_frame_check;
      end
    end
  end

  // Fresh fault occurrence, one cycle after its boundary
  assign fault_new = fault_src & {tick_q[2], {2{tick_q[1]}}, {4{tick_q[0]}}};

  // Masked faults never enter the flags
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_fault_flags <= '0;
    end else if (rd_fault) begin
      rx_fault_flags <= ((rx_fault_flags & fault_src & {7{rx_fault_hold}}) | fault_new)
                        & rx_unmask_eff;
    end else begin
      rx_fault_flags <= (rx_fault_flags | fault_new) & rx_unmask_eff;
    end
  end

  assign rx_fault_level = |(fault_src & rx_error_unmask);
  assign fault_hold_sample = |(fault_src & rx_error_unmask & FLT_SAMPLE_GROUP);

  //////////////////////////////////////////////////////////////////////////
  // Trigger-mode conditions
  arsiu_trigger u_fault_trig (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cond(rx_fault_level),
    .mode(arsiu_trig_t'(irq_trigger_mode[TRIG_RX_FAULT_LSB +: 2])),
    .fire(rx_fault_fire),
    .level_hold(rx_fault_hold)
  );

  arsiu_trigger u_conv_trig (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .cond(converter_lock_lost),
    .mode(arsiu_trig_t'(irq_trigger_mode[TRIG_CONVERTER_LSB +: 2])),
    .fire(conv_fire),
    .level_hold(conv_hold)
  );

  //////////////////////////////////////////////////////////////////////////
  // Channel-status summary and format detection
  always_comb begin
    logic [39:0] cs;
    logic general;
    logic pre_shaping_flag;
    cs = side_select ? cs_b : cs_a;
    general = (cs[CS_CAT_LSB +: 8] == CS_CAT_GENERAL);
    pre_shaping_flag = cs[CS_PRO_BIT] ? (cs[CS_PRO_PRE_SHAPING_FLAG_LSB +: 3] == CS_PRO_PRE_SHAPING_FLAG_5015)
                          : (cs[CS_CON_PRE_SHAPING_FLAG_LSB +: 3] == CS_CON_PRE_SHAPING_FLAG_5015);
    rx_cs_summary[7:4] = side_select ? anc_width_b : anc_width_a;
    rx_cs_summary[3] = cs[CS_PRO_BIT];
    rx_cs_summary[2] = cs[CS_COPY_BIT] & ~general;
    rx_cs_summary[1] = cs[CS_L_BIT];
    rx_cs_summary[0] = ~pre_shaping_flag;
    if (cs[CS_PRO_BIT] || !rx_in_use) begin
      rx_cs_summary[2] = 1'b1;
      rx_cs_summary[1] = 1'b1;
    end
  end

  arsiu_silence u_silence (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .sample_tick(sample_tick),
    .sample_l(sample_l),
    .sample_r(sample_r),
    .silence(silence_found)
  );

  // Priority keeps the four stream types exclusive
  always_comb begin
    stream_format_detect = '0;
    if (pcm_found) begin
      stream_format_detect[FMT_PCM] = 1'b1;
    end else if (burst_found) begin
      stream_format_detect[FMT_BURST] = 1'b1;
    end else if (compressed_a_found) begin
      stream_format_detect[FMT_COMP_A] = 1'b1;
    end else if (compressed_b_found) begin
      stream_format_detect[FMT_COMP_B] = 1'b1;
    end
    stream_format_detect[FMT_EXT_DISC] = extended_disc_found;
    stream_format_detect[FMT_SILENCE] = silence_found;
  end

  //////////////////////////////////////////////////////////////////////////
  // Event history
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_q <= '0;
      burst_type_prev <= '0;
      cs_prev <= '0;
    end else begin
      fmt_q <= stream_format_detect;
      if (burst_type_tick) begin
        burst_type_prev <= burst_type_byte;
      end
      if (cs_block_tick) begin
        cs_prev <= {cs_b, cs_a};
      end
    end
  end

  assign fmt_rise = rise(stream_format_detect, fmt_q);
  assign burst_change_evt = (burst_type_tick && burst_type_byte != burst_type_prev)
                          || fmt_rise[FMT_BURST];
  assign cs_change_evt = cs_block_tick && ({cs_b, cs_a} != cs_prev);

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_BURST_TYPE_CHANGED] = burst_change_evt;
    irq_events[IRQ_OUTPUT_SAMPLE_SKIP] = output_sample_skip & out_port_slave
                                       & out_frame_clock_async;
    irq_events[IRQ_CS_BUFFER_MOVED] = cs_buffer_moved;
    irq_events[IRQ_CS_CONTENT_CHANGED] = cs_change_evt;
    irq_events[IRQ_RX_FAULT_SUMMARY] = rx_fault_fire;
    irq_events[IRQ_SUBCODE_BLOCK_READY] = subcode_block_ready;
    irq_events[IRQ_STREAM_FORMAT_CHANGED] = |{fmt_rise[FMT_PCM:FMT_COMP_B],
                                              fmt_rise[FMT_SILENCE]};
    irq_events[IRQ_CONVERTER_LOCK_LOST] = conv_fire;
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status and output
  always_comb begin
    status_keep = '0;
    status_keep[IRQ_RX_FAULT_SUMMARY] = rx_fault_hold;
    status_keep[IRQ_CONVERTER_LOCK_LOST] = conv_hold;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_status <= '0;
    end else if (rd_status) begin
      irq_status <= ((irq_status & status_keep) | irq_events) & irq_unmask_eff;
    end else begin
      irq_status <= (irq_status | irq_events) & irq_unmask_eff;
    end
  end

  assign irq_active = |irq_status;

  // Polarity alone decides the pin level
  always_comb begin
    case (int_polarity)
      POL_LOW: begin
        irq_pin = ~irq_active;
        irq_pin_oe_n = 1'b0;
      end
      POL_LOW_OPEN_DRAIN: begin
        irq_pin = 1'b0;
        irq_pin_oe_n = ~irq_active;
      end
      default: begin
        irq_pin = irq_active;
        irq_pin_oe_n = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port
  always_comb begin
    case (reg_addr)
      ADDR_RX_ERROR_UNMASK: next_rdata = {1'b0, rx_error_unmask};
      ADDR_IRQ_UNMASK: next_rdata = irq_unmask;
      ADDR_IRQ_TRIGGER_MODE: next_rdata = irq_trigger_mode;
      ADDR_RX_CS_SUMMARY: next_rdata = rx_cs_summary;
      ADDR_STREAM_FORMAT_DETECT: next_rdata = stream_format_detect;
      ADDR_RX_FAULT_FLAGS: next_rdata = {1'b0, rx_fault_flags};
      ADDR_IRQ_STATUS: next_rdata = irq_status;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  property p_masked_zero;
    @(posedge core_clk) disable iff (!arst_n)
    ((irq_status & ~irq_unmask) == 8'h00) and ((rx_fault_flags & ~rx_error_unmask) == 7'h00);
  endproperty
  a_masked_zero: assert property (p_masked_zero) else $error("masked bit set");
  property p_event_sets;
    @(posedge core_clk) disable iff (!arst_n)
    (irq_events[IRQ_CS_BUFFER_MOVED] && irq_unmask_eff[IRQ_CS_BUFFER_MOVED])
      |=> irq_status[IRQ_CS_BUFFER_MOVED];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("event not latched");
  property p_read_clears;
    @(posedge core_clk) disable iff (!arst_n)
    (rd_status && irq_events == 8'h00 && !rx_fault_hold && !conv_hold)
      |=> irq_status == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared");
  property p_sticky;
    @(posedge core_clk) disable iff (!arst_n)
    (!rd_status && irq_status[IRQ_SUBCODE_BLOCK_READY] && irq_unmask_eff[IRQ_SUBCODE_BLOCK_READY])
      |=> irq_status[IRQ_SUBCODE_BLOCK_READY];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status lost");
  property p_onset_conv;
    @(posedge core_clk) disable iff (!arst_n)
    (irq_trigger_mode[1:0] == 2'b00 && converter_lock_lost && $past(converter_lock_lost))
      |-> !conv_fire;
  endproperty
  a_onset_conv: assert property (p_onset_conv) else $error("onset refired");
  property p_removal_conv;
    @(posedge core_clk) disable iff (!arst_n)
    (irq_trigger_mode[1:0] == 2'b01 && $fell(converter_lock_lost)) |-> conv_fire;
  endproperty
  a_removal_conv: assert property (p_removal_conv) else $error("removal missed");
  property p_exclusive;
    @(posedge core_clk) disable iff (!arst_n)
    $onehot0(stream_format_detect[FMT_PCM:FMT_COMP_B]);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("formats overlap");
  property p_fall_quiet;
    @(posedge core_clk) disable iff (!arst_n)
    (stream_format_detect[FMT_SILENCE:FMT_SILENCE] == 1'b0 && fmt_q[FMT_SILENCE]
     && stream_format_detect[FMT_PCM:FMT_COMP_B] == 4'h0 && fmt_q[FMT_PCM:FMT_COMP_B] == 4'h0)
      |-> !irq_events[IRQ_STREAM_FORMAT_CHANGED];
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("fall raised change");
  property p_forced_flags;
    @(posedge core_clk) disable iff (!arst_n)
    !rx_in_use |-> rx_cs_summary[2:1] == 2'b11;
  endproperty
  a_forced_flags: assert property (p_forced_flags) else $error("flags not forced");
  property p_rdata_lat;
    @(posedge core_clk) disable iff (!arst_n)
    (reg_rd && reg_addr == ADDR_IRQ_UNMASK && !reg_wr) |=> reg_rdata == $past(irq_unmask);
  endproperty
  a_rdata_lat: assert property (p_rdata_lat) else $error("read data wrong");
  c_irq: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(irq_active));
  c_fault_read: cover property (@(posedge core_clk) disable iff (!arst_n)
    rx_fault_flags != 7'h00 ##1 rd_fault);
  c_silence: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(silence_found));

endmodule
`default_nettype wire

// *** test/arsiu_host_model.sv ***
// Host model watching the interrupt pin.
// Assumes a pull-up on the pin while it is released.
`timescale 1ns/1ps
`default_nettype none
module arsiu_host_model
  import arsiu_pkg::*;
(
  input wire logic irq_pin,
  input wire logic irq_pin_oe_n,
  input wire logic [1:0] int_polarity,
  output logic irq_seen
);
  logic pin_level;
  // Released pin is pulled up
  assign pin_level = irq_pin_oe_n ? 1'b1 : irq_pin;
  // Low codes read inverted
  assign irq_seen = (int_polarity inside {POL_LOW, POL_LOW_OPEN_DRAIN}) ? ~pin_level : pin_level;
endmodule
`default_nettype wire

// *** test/arsiu_top_tb.sv ***
// Self-checking bench of the status and interrupt unit.
// Assumes the host model and the design files compiled before it.
`timescale 1ns/1ps
`default_nettype none
module arsiu_top_tb;
  import arsiu_pkg::*;
  logic core_clk = '0, arst_n = '0, reg_wr = '0, reg_rd = '0, subframe_tick = '0;
  logic cs_block_tick = '0, subcode_block_tick = '0, err_validity = '0, err_trust = '0;
  logic err_line_code = '0, err_frame_check = '0, err_cs_check = '0, err_subcode_check = '0;
  logic rx_unlocked = '0, rx_in_use = '0, side_select = '0, pcm_found = '0, burst_found = '0;
  logic compressed_a_found = '0, compressed_b_found = '0, extended_disc_found = '0;
  logic sample_tick = '0, burst_type_tick = '0, out_port_slave = '0, out_frame_clock_async = '0;
  logic output_sample_skip = '0, cs_buffer_moved = '0, subcode_block_ready = '0;
  logic converter_lock_lost = '0;
  logic [7:0] reg_addr = '0, reg_wdata = '0, burst_type_byte = '0, reg_rdata;
  logic [39:0] cs_a = '0, cs_b = '0;
  logic [3:0] anc_width_a = '0, anc_width_b = '0;
  logic [1:0] int_polarity = '0;
  logic [SAMPLE_W-1:0] sample_l = '0, sample_r = '0;
  logic reg_rdata_valid, irq_active, irq_pin, irq_pin_oe_n, fault_hold_sample, irq_seen;
  int num_errors = 0;
  int n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  arsiu_top dut_u (.*);
  arsiu_host_model host_u (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata_valid", 8'h01, {7'h00, reg_rdata_valid});
    chk(nm, e, reg_rdata);
  endtask
  task automatic moved(input logic with_read);
    @(posedge core_clk);
    cs_buffer_moved <= 1'b1;
    reg_addr <= ADDR_IRQ_STATUS;
    reg_rd <= with_read;
    @(posedge core_clk);
    cs_buffer_moved <= 1'b0;
    reg_rd <= 1'b0;
    idle(2);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdchk(ADDR_IRQ_UNMASK, 8'h00, "unmask_rst");
    rdchk(ADDR_IRQ_TRIGGER_MODE, 8'h00, "mode_rst");
    wr(ADDR_IRQ_TRIGGER_MODE, 8'hff);
    rdchk(ADDR_IRQ_TRIGGER_MODE, 8'h0f, "mode_rsvd");
    wr(ADDR_IRQ_TRIGGER_MODE, 8'h00);
    rdchk(8'h40, 8'h00, "unmapped");
  endtask
  task automatic t_mask();
    moved(1'b0);
    rdchk(ADDR_IRQ_STATUS, 8'h00, "masked_evt");
    wr(ADDR_IRQ_UNMASK, 8'h20);
    moved(1'b0);
    for (int p = 0; p < 4; p++) begin
      @(posedge core_clk);
      int_polarity <= p[1:0];
      @(negedge core_clk);
      chk("irq_seen", 8'h01, {7'h00, irq_seen});
      chk("irq_active", 8'h01, {7'h00, irq_active});
    end
    rdchk(ADDR_IRQ_STATUS, 8'h20, "sticky");
    rdchk(ADDR_IRQ_STATUS, 8'h00, "cleared");
    chk("irq_off", 8'h00, {7'h00, irq_seen});
    moved(1'b1);
    rdchk(ADDR_IRQ_STATUS, 8'h20, "same_cycle");
  endtask
  task automatic t_trig();
    wr(ADDR_IRQ_UNMASK, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_IRQ_TRIGGER_MODE, m[7:0]);
      @(posedge core_clk);
      converter_lock_lost <= 1'b1;
      idle(3);
      rdchk(ADDR_IRQ_STATUS, (m == 0 || m == 2) ? 8'h01 : 8'h00, "trig_on");
      rdchk(ADDR_IRQ_STATUS, (m == 2) ? 8'h01 : 8'h00, "trig_hold");
      @(posedge core_clk);
      converter_lock_lost <= 1'b0;
      idle(3);
      rdchk(ADDR_IRQ_STATUS, (m == 1 || m == 2) ? 8'h01 : 8'h00, "trig_off");
    end
  endtask
  task automatic t_fault();
    wr(ADDR_IRQ_TRIGGER_MODE, 8'h00);
    wr(ADDR_RX_ERROR_UNMASK, 8'h01);
    wr(ADDR_IRQ_UNMASK, 8'h08);
    @(posedge core_clk);
    err_frame_check <= 1'b1;
    err_validity <= 1'b1;
    subframe_tick <= 1'b1;
    @(posedge core_clk);
    subframe_tick <= 1'b0;
    idle(3);
    @(negedge core_clk);
    chk("hold", 8'h01, {7'h00, fault_hold_sample});
    rdchk(ADDR_RX_FAULT_FLAGS, 8'h01, "fault_set");
    rdchk(ADDR_IRQ_STATUS, 8'h08, "fault_irq");
    rdchk(ADDR_RX_FAULT_FLAGS, 8'h00, "fault_clr");
  endtask
  task automatic t_sil();
    wr(ADDR_IRQ_UNMASK, 8'h02);
    @(posedge core_clk);
    sample_l <= 24'h00abcd;
    sample_r <= 24'h00abcd;
    sample_tick <= 1'b1;
    idle(2040);
    sample_tick <= 1'b0;
    rdchk(ADDR_STREAM_FORMAT_DETECT, 8'h00, "sil_early");
    @(posedge core_clk);
    sample_tick <= 1'b1;
    idle(10);
    sample_tick <= 1'b0;
    idle(3);
    rdchk(ADDR_STREAM_FORMAT_DETECT, 8'h04, "sil_set");
    rdchk(ADDR_IRQ_STATUS, 8'h02, "sil_fch");
  endtask
  task automatic t_fmt();
    wr(ADDR_IRQ_UNMASK, 8'h82);
    @(posedge core_clk);
    sample_l <= 24'h000001;
    pcm_found <= 1'b1;
    sample_tick <= 1'b1;
    @(posedge core_clk);
    sample_tick <= 1'b0;
    idle(3);
    rdchk(ADDR_STREAM_FORMAT_DETECT, 8'h80, "pcm_only");
    rdchk(ADDR_IRQ_STATUS, 8'h02, "fch_rise");
    @(posedge core_clk);
    pcm_found <= 1'b0;
    extended_disc_found <= 1'b1;
    idle(3);
    rdchk(ADDR_IRQ_STATUS, 8'h00, "fch_none");
    @(posedge core_clk);
    burst_found <= 1'b1;
    idle(3);
    rdchk(ADDR_IRQ_STATUS, 8'h82, "burst_rise");
  endtask
  task automatic t_evt();
    wr(ADDR_IRQ_UNMASK, 8'hd4);
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      out_port_slave <= s[0];
      out_frame_clock_async <= 1'b1;
      output_sample_skip <= 1'b1;
      subcode_block_ready <= 1'b1;
      burst_type_tick <= 1'b1;
      burst_type_byte <= 8'h15;
      cs_block_tick <= 1'b1;
      cs_a[7:0] <= 8'h5a;
      @(posedge core_clk);
      output_sample_skip <= 1'b0;
      subcode_block_ready <= 1'b0;
      burst_type_tick <= 1'b0;
      cs_block_tick <= 1'b0;
      idle(3);
      rdchk(ADDR_IRQ_STATUS, s ? 8'h44 : 8'h94, "evt_set");
    end
  endtask
  task automatic t_sum(input logic sel, input logic on, input logic [15:0] cs, input logic [7:0] e);
    @(posedge core_clk);
    side_select <= sel;
    rx_in_use <= on;
    cs_a <= sel ? ~{24'h000000, cs} : {24'h000000, cs};
    cs_b <= sel ? {24'h000000, cs} : ~{24'h000000, cs};
    anc_width_a <= sel ? 4'h0 : 4'h3;
    anc_width_b <= sel ? 4'h3 : 4'h0;
    idle(3);
    rdchk(ADDR_RX_CS_SUMMARY, e, "summary");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    idle(20);
    arst_n <= 1'b1;
    t_regs();
    t_mask();
    t_trig();
    t_fault();
    t_sil();
    t_fmt();
    t_evt();
    t_sum(1'b0, 1'b1, 16'h010c, 8'h34);
    t_sum(1'b1, 1'b1, 16'h0001, 8'h3f);
    t_sum(1'b0, 1'b1, 16'h000c, 8'h30);
    t_sum(1'b0, 1'b0, 16'h010c, 8'h36);
    t_sum(1'b0, 1'b1, 16'h8114, 8'h37);
    give_verdict();
  end
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
